// ==== scn_defs.svh ====
// Constants of the auto-scan request source
`ifndef SCN_DEFS_SVH
`define SCN_DEFS_SVH

`define SCN_CH_NUM 16
`define SCN_CH_W 4
`define SCN_SEL_RST 16'h0000
`define SCN_PEND_RST 16'h0000
`define SCN_MODE_RST 2'h0

`endif

// ==== scn_pkg.sv ====
// Types of the auto-scan request source
`include "scn_defs.svh"

package scn_pkg;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'h0,
		MODE_SINGLE = 2'h1,
		MODE_CONT = 2'h2,
		MODE_HALT = 2'h3
	} scan_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_BUSY = 2'h2
	} conv_state_type;

	typedef struct packed {
		logic valid;
		logic [`SCN_CH_W-1:0] ch;
	} scan_req_type;

endpackage

// ==== scn_prio_enc.sv ====
// Highest-set-bit encoder
`timescale 1ns/10ps
`default_nettype none

module scn_prio_enc #(
	parameter int WIDTH = 16,
	parameter int IDX_W = 4
)(
	input wire logic [WIDTH-1:0] vec_i,
	output logic [IDX_W-1:0] idx_o,
	output logic valid_o
);

	always_comb
	begin
		idx_o = '0;
		valid_o = 1'b0;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (vec_i[i])
			begin
				idx_o = IDX_W'(i);
				valid_o = 1'b1;
			end
		end
	end

endmodule // scn_prio_enc

`default_nettype wire

// ==== scn_auto_scan.sv ====
// Auto-scan conversion request source
// Behaviour
// - One selection flag per channel marks it as member of the scan group.
// - Selecting a scan mode copies the selection into the pending vector.
// - Participation flag is set whenever any pending bit is set.
// - The highest-numbered pending channel is offered for conversion first.
// - Starting a conversion clears that channel's pending bit.
// - Single mode: after the last channel, mode clears and source idles.
// - Continuous mode reloads the pending vector after each completed sequence.
// - A cancelled conversion sets its channel's pending bit again.
// - Done flag sets when the last channel of a sequence finishes.
// - Service request pulses only with node pointer valid and node enabled.
// - Mode 01 from 00 loads selection and starts single; empty selection clears mode.
// - Mode 10 from 00 loads selection and starts continuous; empty selection clears mode.
// - Mode 11 clears the mode; a running sequence still finishes with request.
// - Mode 00 during a scan finishes the sequence, then starts no more.
// - Switching single/continuous finishes conversion, reloads, starts in new mode.
// - Rewriting the mode continues; continuous also reloads and restarts.
// - Clearing a nonzero selection clears mode and pending vector.
// - Changing selection outside continuous clears mode and pending vector.
// - Changing selection in continuous reloads and starts a new sequence.
// - Clearing participation outside continuous clears mode and pending vector.
// - Clearing participation in continuous reloads and starts a new sequence.
`timescale 1ns/10ps
`default_nettype none
`include "scn_defs.svh"

module scn_auto_scan #(
	parameter int CH_NUM = `SCN_CH_NUM,
	parameter int CH_W = `SCN_CH_W
)(
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic SEL_WR_I,
	input wire logic [CH_NUM-1:0] SEL_DATA_I,
	input wire logic MODE_WR_I,
	input wire scn_pkg::scan_mode_type MODE_DATA_I,
	input wire logic PART_WR_I,
	input wire logic PART_DATA_I,
	input wire logic CONV_START_I,
	input wire logic CONV_CANCEL_I,
	input wire logic CONV_DONE_I,
	input wire logic NODE_PTR_VALID_I,
	input wire logic NODE_ENABLE_I,
	input wire logic DONE_FLAG_CLR_I,
	output logic [CH_NUM-1:0] SCAN_SELECT_O,
	output scn_pkg::scan_mode_type SCAN_MODE_O,
	output logic [CH_NUM-1:0] SCAN_PENDING_O,
	output logic SCAN_PART_O,
	output scn_pkg::scan_req_type SCAN_REQ_O,
	output logic SCAN_BUSY_O,
	output logic SCAN_DONE_FLAG_O,
	output logic SCAN_SRV_REQ_O
);

	logic [CH_NUM-1:0] sel_reg;
	logic [CH_NUM-1:0] pend_reg;
	logic [CH_NUM-1:0] pend_next;
	scn_pkg::scan_mode_type mode_reg;
	scn_pkg::scan_mode_type mode_next;
	scn_pkg::conv_state_type state_reg;
	scn_pkg::conv_state_type state_next;
	scn_pkg::scan_req_type req_reg;
	logic [CH_W-1:0] cur_ch_reg;
	logic part_reg;
	logic last_reg;
	logic last_next;
	logic flag_reg;
	logic srv_reg;
	logic busy_reg;
	logic [CH_W-1:0] enc_idx;
	logic enc_vld;

	wire [CH_NUM-1:0] one_bit = {{(CH_NUM-1){1'b0}}, 1'b1};
	wire busy = (state_reg == scn_pkg::ST_BUSY);
	wire start_hit = CONV_START_I && req_reg.valid;
	wire cancel_hit = CONV_CANCEL_I && busy;
	wire done_hit = CONV_DONE_I && busy && !CONV_CANCEL_I;
	wire seq_end = done_hit && last_reg;
	wire [CH_NUM-1:0] start_mask = start_hit ? (one_bit << req_reg.ch) : '0;
	wire [CH_NUM-1:0] cancel_mask = cancel_hit ? (one_bit << cur_ch_reg) : '0;
	wire [CH_NUM-1:0] pend_hw = (pend_reg & ~start_mask) | cancel_mask;
	wire [CH_NUM-1:0] sel_new = SEL_WR_I ? SEL_DATA_I : sel_reg;
	wire sel_new_nz = |sel_new;
	wire is_cont = (mode_reg == scn_pkg::MODE_CONT);
	wire cont_keep = is_cont && !(MODE_WR_I && !((MODE_DATA_I == scn_pkg::MODE_SINGLE)
		|| (MODE_DATA_I == scn_pkg::MODE_CONT)));
	wire wr_run = (MODE_DATA_I == scn_pkg::MODE_SINGLE) || (MODE_DATA_I == scn_pkg::MODE_CONT);
	wire wr_same_single = (mode_reg == scn_pkg::MODE_SINGLE)
		&& (MODE_DATA_I == scn_pkg::MODE_SINGLE);
	wire mode_load = MODE_WR_I && wr_run && !wr_same_single;
	// stop keeps pending so sequence finishes
	wire mode_stop = MODE_WR_I && !wr_run;
	wire sel_chg = SEL_WR_I && (|sel_reg);
	wire sel_reload = sel_chg && (|SEL_DATA_I) && cont_keep;
	wire sel_kill = sel_chg && !sel_reload;
	// only a clear of a set flag acts
	wire part_clr = PART_WR_I && !PART_DATA_I && part_reg;
	wire part_reload = part_clr && cont_keep;
	wire part_kill = part_clr && !cont_keep;
	wire sw_kill = sel_kill || part_kill;
	wire auto_reload = seq_end && cont_keep && (pend_hw == '0);
	wire single_end = seq_end && (mode_reg == scn_pkg::MODE_SINGLE);
	wire any_load = (mode_load && sel_new_nz) || sel_reload || part_reload || auto_reload;

	assign pend_next = sw_kill ? '0 : (any_load ? sel_new : pend_hw);

	always_comb
	begin
		mode_next = mode_reg;
		if (sw_kill)
		begin
			mode_next = scn_pkg::MODE_IDLE;
		end
		else if (mode_load)
		begin
			mode_next = sel_new_nz ? MODE_DATA_I : scn_pkg::MODE_IDLE;
		end
		else if (mode_stop || single_end)
		begin
			mode_next = scn_pkg::MODE_IDLE;
		end
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			scn_pkg::ST_IDLE:
			begin
				if (start_hit)
				begin
					state_next = scn_pkg::ST_BUSY;
				end
			end
			scn_pkg::ST_BUSY:
			begin
				if (start_hit)
				begin
					state_next = scn_pkg::ST_BUSY;
				end
				else if (cancel_hit || done_hit)
				begin
					state_next = scn_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_next = scn_pkg::ST_IDLE;
			end
		endcase
	end

	// A conversion is the last one when nothing stays pending behind it
	assign last_next = start_hit ? (pend_next == '0) : (sw_kill ? 1'b1 : last_reg);

	scn_prio_enc #(
		.WIDTH(CH_NUM),
		.IDX_W(CH_W)
	) u_enc (
		.vec_i(pend_next),
		.idx_o(enc_idx),
		.valid_o(enc_vld)
	);

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			sel_reg <= CH_NUM'(`SCN_SEL_RST);
			pend_reg <= CH_NUM'(`SCN_PEND_RST);
			mode_reg <= scn_pkg::scan_mode_type'(`SCN_MODE_RST);
			state_reg <= scn_pkg::ST_IDLE;
			part_reg <= 1'b0;
			last_reg <= 1'b0;
			cur_ch_reg <= '0;
			req_reg <= '0;
			flag_reg <= 1'b0;
			srv_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			sel_reg <= sel_new;
			pend_reg <= pend_next;
			mode_reg <= mode_next;
			state_reg <= state_next;
			busy_reg <= (state_next == scn_pkg::ST_BUSY);
			part_reg <= |pend_next;
			last_reg <= last_next;
			cur_ch_reg <= start_hit ? req_reg.ch : cur_ch_reg;
			req_reg <= '{valid: enc_vld, ch: enc_idx};
			flag_reg <= seq_end || (flag_reg && !DONE_FLAG_CLR_I);
			srv_reg <= seq_end && NODE_PTR_VALID_I && NODE_ENABLE_I;
		end
	end

	assign SCAN_SELECT_O = sel_reg;
	assign SCAN_MODE_O = mode_reg;
	assign SCAN_PENDING_O = pend_reg;
	assign SCAN_PART_O = part_reg;
	assign SCAN_REQ_O = req_reg;
	assign SCAN_BUSY_O = busy_reg;
	assign SCAN_DONE_FLAG_O = flag_reg;
	assign SCAN_SRV_REQ_O = srv_reg;

	property p_part_follows;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		part_reg == (|pend_reg);
	endproperty
	a_part_follows: assert property (p_part_follows)
		else $error("participation flag differs from pending vector");

	property p_highest;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		req_reg.valid |-> ((pend_reg >> req_reg.ch) == one_bit);
	endproperty
	a_highest: assert property (p_highest)
		else $error("offered channel is not the highest pending one");

	property p_start_clears;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(start_hit && !any_load && !sw_kill) |=> ((pend_reg & $past(start_mask)) == '0);
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("started channel still pending");

	property p_cancel_requeue;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(cancel_hit && !any_load && !sw_kill) |=> pend_reg[$past(cur_ch_reg)];
	endproperty
	a_cancel_requeue: assert property (p_cancel_requeue)
		else $error("cancelled channel not requeued");

	property p_single_end;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(single_end && !MODE_WR_I) |=> (mode_reg == scn_pkg::MODE_IDLE);
	endproperty
	a_single_end: assert property (p_single_end)
		else $error("single mode not cleared at end of sequence");

	property p_cont_reload;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(auto_reload && !sw_kill) |=> (pend_reg == $past(sel_new)) && part_reg == (|pend_reg);
	endproperty
	a_cont_reload: assert property (p_cont_reload)
		else $error("continuous scan did not restart");

	property p_mode_load;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(mode_load && sel_new_nz && !sw_kill)
			|=> (pend_reg == $past(sel_new)) && (mode_reg == $past(MODE_DATA_I));
	endproperty
	a_mode_load: assert property (p_mode_load)
		else $error("mode write did not load the selection");

	property p_empty_sel;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(MODE_WR_I && wr_run && !sel_new_nz) |=> (mode_reg == scn_pkg::MODE_IDLE);
	endproperty
	a_empty_sel: assert property (p_empty_sel)
		else $error("mode kept with empty selection");

	property p_halt;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(mode_stop && !sw_kill && !start_hit && !cancel_hit)
			|=> (mode_reg == scn_pkg::MODE_IDLE) && (pend_reg == $past(pend_reg));
	endproperty
	a_halt: assert property (p_halt)
		else $error("stop write did not let the sequence finish");

	property p_kill;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		sw_kill |=> (pend_reg == '0) && (mode_reg == scn_pkg::MODE_IDLE) && !part_reg;
	endproperty
	a_kill: assert property (p_kill)
		else $error("selection or participation clear did not stop the scan");

	property p_flag_set;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		seq_end |=> flag_reg ##1 (flag_reg || $past(DONE_FLAG_CLR_I));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("done flag not set at end of sequence");

	property p_srv_gate;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		srv_reg |-> $past(seq_end && NODE_PTR_VALID_I && NODE_ENABLE_I);
	endproperty
	a_srv_gate: assert property (p_srv_gate)
		else $error("service request without enabled node");

	property p_part_noop;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(PART_WR_I && !part_clr && !SEL_WR_I && !MODE_WR_I && !start_hit && !cancel_hit
			&& !done_hit) |=> (pend_reg == $past(pend_reg)) && (mode_reg == $past(mode_reg));
	endproperty
	a_part_noop: assert property (p_part_noop)
		else $error("ineffective participation write changed state");

	property p_sel_reload;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(sel_reload && !MODE_WR_I && !PART_WR_I)
			|=> (pend_reg == $past(SEL_DATA_I)) && (mode_reg == scn_pkg::MODE_CONT);
	endproperty
	a_sel_reload: assert property (p_sel_reload)
		else $error("continuous selection change did not restart the scan");

	property p_part_reload;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(part_reload && !MODE_WR_I && !SEL_WR_I)
			|=> (pend_reg == $past(sel_reg)) && (mode_reg == scn_pkg::MODE_CONT);
	endproperty
	a_part_reload: assert property (p_part_reload)
		else $error("continuous participation clear did not restart the scan");

	property p_idle_drain;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		((mode_reg == scn_pkg::MODE_IDLE) && !MODE_WR_I && !start_hit && !cancel_hit
			&& !sw_kill) |=> (pend_reg == $past(pend_reg)) && (mode_reg == scn_pkg::MODE_IDLE);
	endproperty
	a_idle_drain: assert property (p_idle_drain)
		else $error("stopped scan started a further sequence");

	property p_mode_switch;
		@(posedge SYS_CLK_I) disable iff (RST_I)
		(MODE_WR_I && (MODE_DATA_I == scn_pkg::MODE_SINGLE) && is_cont && sel_new_nz && !sw_kill)
			|=> (mode_reg == scn_pkg::MODE_SINGLE) && (pend_reg == $past(sel_new));
	endproperty
	a_mode_switch: assert property (p_mode_switch)
		else $error("switch to single mode did not reload the selection");

endmodule // scn_auto_scan

`default_nettype wire

// ==== scn_arb_model.sv ====
// Behavioural conversion arbiter facing the scan source
`timescale 1ns/10ps
`default_nettype none

module scn_arb_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire scn_pkg::scan_req_type req_i,
	input wire logic slow_i,
	input wire logic cancel_i,
	output logic start_o,
	output logic cancel_o,
	output logic done_o
);
	logic act = 1'h0;
	int cnt = 0;
	initial {start_o, cancel_o, done_o} = 3'h0;
	// Start on a valid request, then end the conversion or abort it
	always @(negedge clk_i)
	begin
		start_o <= 1'h0;
		cancel_o <= 1'h0;
		done_o <= 1'h0;
		if (rst_i)
			act <= 1'h0;
		else if (act && cnt > 0)
			cnt <= cnt - 1;
		else if (act)
		begin
			act <= 1'h0;
			cancel_o <= cancel_i;
			done_o <= !cancel_i;
		end
		else if (req_i.valid)
		begin
			start_o <= 1'h1;
			act <= 1'h1;
			cnt <= slow_i ? 8 : 1;
		end
	end
endmodule // scn_arb_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of the auto-scan request source
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic clk = 1'h1;
	logic rst = 1'h1;
	logic sel_wr = 1'h0, mode_wr = 1'h0, part_wr = 1'h0, part_d = 1'h0;
	logic nptr = 1'h1, nen = 1'h1, fclr = 1'h0, slow = 1'h0, cxl = 1'h0;
	logic [15:0] sel_d = 16'h0;
	scn_pkg::scan_mode_type mode_d = scn_pkg::MODE_IDLE;
	logic st, cn, dn, part_o, busy_o, flag_o, srv_o;
	logic [15:0] sel_o, pend_o, s, s2, p;
	scn_pkg::scan_mode_type mode_o;
	scn_pkg::scan_req_type req_o;
	int fail_count = 0, n_checks = 0, srv_n = 0, cxl_n = 0, b = 0;
	int unsigned exp_q[$];

	scn_auto_scan i_scn_auto_scan (.SYS_CLK_I(clk), .RST_I(rst), .SEL_WR_I(sel_wr),
		.SEL_DATA_I(sel_d), .MODE_WR_I(mode_wr), .MODE_DATA_I(mode_d), .PART_WR_I(part_wr),
		.PART_DATA_I(part_d), .CONV_START_I(st), .CONV_CANCEL_I(cn), .CONV_DONE_I(dn),
		.NODE_PTR_VALID_I(nptr), .NODE_ENABLE_I(nen), .DONE_FLAG_CLR_I(fclr),
		.SCAN_SELECT_O(sel_o), .SCAN_MODE_O(mode_o), .SCAN_PENDING_O(pend_o),
		.SCAN_PART_O(part_o), .SCAN_REQ_O(req_o), .SCAN_BUSY_O(busy_o),
		.SCAN_DONE_FLAG_O(flag_o), .SCAN_SRV_REQ_O(srv_o));
	scn_arb_model i_scn_arb_model (.clk_i(clk), .rst_i(rst), .req_i(req_o), .slow_i(slow),
		.cancel_i(cxl), .start_o(st), .cancel_o(cn), .done_o(dn));

	initial forever #4 clk = ~clk;

	task summarize;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One software write: 0 selection, 1 mode, 2 participation
	task wr(input int k, input logic [15:0] d);
		@(negedge clk);
		sel_wr = (k == 0);
		mode_wr = (k == 1);
		part_wr = (k == 2);
		sel_d = d;
		mode_d = scn_pkg::scan_mode_type'(d[1:0]);
		part_d = d[0];
		@(negedge clk);
		{sel_wr, mode_wr, part_wr} = 3'h0;
	endtask

	// Bounded wait: 0 start taken, 1 idle and request counted, 2 service count reached, 3 cancel seen
	task automatic wt(input int c);
		int n = 0;
		while (!((c == 0 && st === 1'h1) || (c == 2 && srv_n >= b) || (c == 3 && cxl_n > 0)
			|| (c == 1 && mode_o === scn_pkg::MODE_IDLE && busy_o === 1'h0 && part_o === 1'h0
			&& srv_o === 1'h0)))
		begin
			@(negedge clk);
			n++;
			if (n > 3000)
			begin
				fail_count++;
				summarize();
			end
		end
	endtask

	task push(input logic [15:0] v);
		for (int i = 15; i >= 0; i--)
			if (v[i])
				exp_q.push_back(i);
	endtask

	always @(posedge clk)
		if (!rst)
		begin
			if (st && req_o.valid && exp_q.size() > 0)
				check(16'(req_o.ch), 16'(exp_q.pop_front()));
			srv_n += 32'(srv_o);
			cxl_n += 32'(cn);
		end

	initial
	begin
		void'($urandom(27390));
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		check(sel_o | pend_o | 16'(mode_o), 16'h0);
		s = 16'h8421;
		wr(0, s);
		check(sel_o, s);
		wr(1, 16'h1);
		check(pend_o, s);
		check(16'({part_o, mode_o}), 16'h5);
		push(s);
		b = srv_n + 1;
		wt(1);
		check(16'(srv_n), 16'(b));
		check(16'({flag_o, exp_q.size() == 0}), 16'h3);
		fclr = 1'h1;
		@(negedge clk);
		fclr = 1'h0;
		check(16'(flag_o), 16'h0);
		for (int k = 1; k < 3; k++)
		begin
			{nptr, nen} = 2'(k);
			s = 16'($urandom()) | 16'h1;
			wr(0, s);
			wr(1, 16'h1);
			push(s);
			b = srv_n;
			wt(1);
			check(16'({flag_o, srv_n == b}), 16'h3);
		end
		{nptr, nen} = 2'h3;
		wr(0, 16'h0);
		for (int k = 1; k < 4; k++)
		begin
			wr(1, 16'(k));
			check(16'(mode_o), 16'h0);
		end
		s = 16'h0003;
		wr(0, s);
		cxl = 1'h1;
		cxl_n = 0;
		exp_q.push_back(1);
		push(s);
		wr(1, 16'h1);
		wt(3);
		cxl = 1'h0;
		check(pend_o, s);
		wt(1);
		check(16'(exp_q.size()), 16'h0);
		slow = 1'h1;
		s = 16'($urandom()) | 16'h8001;
		s2 = s ^ 16'h0100;
		wr(0, s);
		wr(1, 16'h2);
		check(16'(mode_o), 16'h2);
		push(s);
		push(s);
		b = srv_n + 1;
		wt(2);
		check(pend_o | 16'h8000, s);
		b++;
		wt(2);
		check(16'(exp_q.size()), 16'h0);
		exp_q.delete();
		wt(0);
		wr(1, 16'h2);
		check(pend_o, s);
		p = pend_o;
		wr(2, 16'h1);
		check(pend_o, p);
		wr(2, 16'h0);
		check(16'(mode_o), 16'h2);
		wt(0);
		wr(0, s2);
		check(16'(mode_o), 16'h2);
		wr(1, 16'h1);
		wt(1);
		check(16'(mode_o), 16'h0);
		for (int k = 0; k < 4; k += 3)
		begin
			wr(1, 16'h2);
			wt(0);
			wr(1, 16'(k));
			check(16'(mode_o), 16'h0);
			b = srv_n + 1;
			wt(1);
			check(16'(srv_n), 16'(b));
		end
		for (int k = 0; k < 3; k++)
		begin
			wr(0, s);
			wr(1, (k == 2) ? 16'h2 : 16'h1);
			wt(0);
			wr((k == 0) ? 2 : 0, (k == 1) ? s2 : 16'h0);
			check(pend_o | 16'(mode_o), 16'h0);
			wt(1);
		end
		summarize();
	end
endmodule // testbench
`default_nettype wire
